/* File: dspd_ctrl.sv */
/*
 * controller that drives the dual strobe page memory through its pins.
 * user side is a valid/ready request port; page hits reuse the open row.
 * assumes REF_CLK at 10 MHz and memory data lines resolved by the testbench.
 */
`timescale 1ns/100ps
`default_nettype none
module dspd_ctrl #(
   parameter int REFRESH_CYC = dspd_pkg::REFRESH_INTERVAL_CYC
) (
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic REQ_VALID,
   output logic REQ_READY,
   input wire dspd_pkg::dspd_req_s REQ,
   output logic RSP_VALID,
   output logic [15:0] RSP_DATA,
   output dspd_pkg::dspd_pins_s PINS,
   input wire logic [15:0] DQ_IN,
   output logic [15:0] DQ_OUT,
   output logic [15:0] DQ_OE
);
   import dspd_pkg::*;
   // ************************************************************
   // state and storage
   // ************************************************************
   typedef enum {S_IDLE, S_ROW, S_COL, S_STROBE, S_PRE, S_CLOSE,
                 S_REF_CAS, S_REF_RAS, S_REF_END} dspd_state_e;
   dspd_state_e state_ff;        // sequencer state
   dspd_pins_s pins_ff;          // registered pin levels
   dspd_req_s req_ff;            // request in flight
   logic row_open_ff;            // a row is held open (page mode)
   logic [8:0] open_row_ff;      // row held open
   logic [15:0] rdata_ff;        // captured read data
   logic rsp_ff;                 // response pulse
   logic [15:0] dq_out_ff;       // write data driven
   logic [15:0] dq_oe_ff;        // per-lane drive enable
   logic [23:0] ref_cnt_ff;      // refresh interval counter
   logic ref_due_ff;             // refresh pending
   logic tmr_load;               // timer load strobe
   logic [3:0] tmr_count;        // timer load value
   logic tmr_done;               // timer expiry
   logic [15:0] lane_mask;       // data lines owned by requested lanes
   logic page_hit;               // request lands in the open row
   // ************************************************************
   // access timer
   // ************************************************************
   dspd_timer #(.W(4)) u_timer (
      .REF_CLK(REF_CLK),
      .RST(RST),
      .load(tmr_load),
      .count(tmr_count),
      .done(tmr_done)
   );
   // lane map: lower strobe owns lines 8..15, upper strobe lines 0..7
   assign lane_mask = {{8{req_ff.lanes[1]}}, {8{req_ff.lanes[0]}}}; // see RQ1
   assign page_hit = row_open_ff && (REQ.addr[17:ROW_LSB] == open_row_ff); // see RQ8
   assign REQ_READY = (state_ff == S_IDLE) && !ref_due_ff;
   // timer loads in S_ROW, S_COL and S_PRE; only S_STROBE waits on it
   always_comb begin
      tmr_load = 1'b0;
      tmr_count = 4'h0;
      unique case (state_ff)
         S_ROW: begin
            tmr_load = 1'b1;
            tmr_count = 4'(ROW_ACCESS_CYC); // see RQ20
         end
         S_COL: begin
            tmr_load = 1'b1;
            // column access or strobe access, whichever is longer
            tmr_count = 4'((COL_ACCESS_CYC > STROBE_ACCESS_CYC) ?
                           COL_ACCESS_CYC : STROBE_ACCESS_CYC); // see RQ10
         end
         S_PRE: begin
            tmr_load = 1'b1;
            tmr_count = 4'(PRE_ACCESS_CYC); // see RQ11
         end
         default: begin
            tmr_load = 1'b0;
         end
      endcase
   end
   // ************************************************************
   // refresh scheduler
   // ************************************************************
   // one row per interval keeps all 512 inside the period
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         ref_cnt_ff <= 24'h000000;
         ref_due_ff <= 1'b0;
      end else begin
         if (ref_cnt_ff >= 24'(REFRESH_CYC - 1)) begin
            ref_cnt_ff <= 24'h000000;
            ref_due_ff <= 1'b1; // see RQ22
         end else begin
            ref_cnt_ff <= ref_cnt_ff + 24'h000001;
            if (state_ff == S_REF_END) begin
               ref_due_ff <= 1'b0;
            end
         end
      end
   end
   // ************************************************************
   // sequencer: pins change a whole cycle apart, so every 100 ns
   // step exceeds the short pulse, setup and precharge minima
   // ************************************************************
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         state_ff <= S_IDLE;
         pins_ff <= '{ras_n: 1'b1, lower_byte_column_strobe_n: 1'b1, upper_byte_column_strobe_n: 1'b1, we_n: 1'b1,
                      oe_n: 1'b1, addr: 9'h000};
         req_ff <= '0;
         row_open_ff <= 1'b0;
         open_row_ff <= 9'h000;
         dq_out_ff <= 16'h0000;
         dq_oe_ff <= 16'h0000;
      end else begin
         unique case (state_ff)
            S_IDLE: begin
               if (ref_due_ff) begin
                  // close any open row before refresh
                  pins_ff.ras_n <= 1'b1;
                  row_open_ff <= 1'b0;
                  state_ff <= S_REF_CAS;
               end else if (REQ_VALID) begin
                  req_ff <= REQ;
                  if (page_hit) begin
                     // page hit: column goes out while strobes are high
                     pins_ff.addr <= REQ.addr[8:COL_LSB]; // see RQ9
                     pins_ff.we_n <= !REQ.write; // see RQ15
                     state_ff <= S_COL;
                  end else if (row_open_ff) begin
                     // miss: close row first, precharge two cycles
                     pins_ff.ras_n <= 1'b1;
                     row_open_ff <= 1'b0;
                     state_ff <= S_CLOSE;
                  end else begin
                     pins_ff.addr <= REQ.addr[17:ROW_LSB]; // see RQ13
                     state_ff <= S_ROW;
                  end
               end
            end
            S_CLOSE: begin
               pins_ff.addr <= req_ff.addr[17:ROW_LSB]; // see RQ12
               state_ff <= S_ROW;
            end
            S_ROW: begin
               // address stable a cycle earlier, now the row strobe falls
               pins_ff.ras_n <= 1'b0; // see RQ14
               row_open_ff <= 1'b1;
               open_row_ff <= req_ff.addr[17:ROW_LSB];
               state_ff <= S_COL;
            end
            S_COL: begin
               if (!pins_ff.ras_n && pins_ff.addr != req_ff.addr[8:0]) begin
                  pins_ff.addr <= req_ff.addr[8:COL_LSB]; // see RQ12
               end
               pins_ff.we_n <= !req_ff.write;
               // early write: write data on lines and write select low first
               dq_out_ff <= req_ff.wdata;
               dq_oe_ff <= req_ff.write ? lane_mask : 16'h0000; // see RQ18
               pins_ff.oe_n <= req_ff.write; // see RQ16
               state_ff <= S_STROBE;
            end
            S_STROBE: begin
               // both requested strobes fall together: one shared capture
               pins_ff.lower_byte_column_strobe_n <= !req_ff.lanes[1]; // see RQ2
               pins_ff.upper_byte_column_strobe_n <= !req_ff.lanes[0]; // see RQ6
               if (tmr_done) begin
                  state_ff <= S_PRE;
               end
            end
            S_PRE: begin
               // raise both strobes together before next column
               pins_ff.lower_byte_column_strobe_n <= 1'b1; // see RQ4
               pins_ff.upper_byte_column_strobe_n <= 1'b1; // see RQ7
               pins_ff.oe_n <= 1'b1;
               pins_ff.we_n <= 1'b1;
               dq_oe_ff <= 16'h0000;
               state_ff <= S_IDLE;
            end
            S_REF_CAS: begin
               // strobe before row strobe: device picks the row
               pins_ff.lower_byte_column_strobe_n <= 1'b0; // see RQ24
               state_ff <= S_REF_RAS;
            end
            S_REF_RAS: begin
               pins_ff.ras_n <= 1'b0;
               state_ff <= S_REF_END;
            end
            S_REF_END: begin
               pins_ff.ras_n <= 1'b1;
               pins_ff.lower_byte_column_strobe_n <= 1'b1;
               state_ff <= S_IDLE;
            end
         endcase
      end
   end
   // ************************************************************
   // read capture: data valid while strobes and enable are low
   // ************************************************************
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         rdata_ff <= 16'h0000;
         rsp_ff <= 1'b0;
      end else begin
         rsp_ff <= 1'b0;
         if (state_ff == S_STROBE && tmr_done && !req_ff.write) begin
            // only strobed lanes carry data; others read as zero
            rdata_ff <= DQ_IN & lane_mask; // see RQ3
            rsp_ff <= 1'b1; // see RQ19
         end else if (state_ff == S_STROBE && tmr_done) begin
            rsp_ff <= 1'b1;
         end
      end
   end
   assign RSP_VALID = rsp_ff;
   assign RSP_DATA = rdata_ff;
   assign PINS = pins_ff;
   assign DQ_OUT = dq_out_ff;
   assign DQ_OE = dq_oe_ff;
endmodule : dspd_ctrl
`default_nettype wire

/* File: dspd_pkg.sv */
/*
 * shared constants and types for the dual strobe page memory controller.
 * assumes a single 10 MHz clock; every time is rounded to whole cycles here.
 */
//
// Operation
// (RQ1) two column strobes gate one byte lane each
// (RQ2) column captured on first falling column strobe
// (RQ3) each strobe enables only its own lane
// (RQ4) both strobes high before a new column
// (RQ5) overlap strobes when keeping column address valid
// (RQ6) early write stores lanes whose strobe is low
// (RQ7) hold strobe pulse width, then precharge
// (RQ8) page mode keeps row across columns
// (RQ9) column buffers transparent until first strobe
// (RQ10) read valid after address or strobe access time
// (RQ11) next page access counted from last rise
// (RQ12) nine row then nine column address bits
// (RQ13) address stable before each capturing edge
// (RQ14) row strobe opens row, column strobe selects
// (RQ15) write select high reads, low writes
// (RQ16) early write keeps outputs floating
// (RQ17) delayed write captures data on write fall
// (RQ18) raise output enable before driving write data
// (RQ19) outputs float until strobe and enable low
// (RQ20) read valid after strobe access time
// (RQ21) outputs unlatched, follow strobes directly
// (RQ22) refresh all 512 rows within 8 ms
// (RQ23) outputs driven only with all strobes low; the model drives each lane on its own strobe alone
// (RQ24) strobe before row strobe performs refresh
package dspd_pkg;
   // ************************************************************
   // timing figures, in their printed units
   // ************************************************************
   localparam int CLK_NS = 100;             // reference clock period
   localparam int ROW_ACCESS_NS = 60;       // row strobe access time
   localparam int STROBE_ACCESS_NS = 15;    // strobe access time
   localparam int COL_ADDR_ACCESS_NS = 30;  // column address access time
   localparam int PRECHARGE_ACCESS_NS = 35; // precharge access time
   localparam int REFRESH_MS = 8;           // whole array refresh period
   localparam int REFRESH_ROWS = 512;       // rows per period
   // ************************************************************
   // derived cycle counts; least times round up
   // ************************************************************
   localparam int ROW_ACCESS_CYC = (ROW_ACCESS_NS + CLK_NS - 1) / CLK_NS;
   localparam int STROBE_ACCESS_CYC = (STROBE_ACCESS_NS + CLK_NS - 1) / CLK_NS;
   localparam int COL_ACCESS_CYC = (COL_ADDR_ACCESS_NS + CLK_NS - 1) / CLK_NS;
   localparam int PRE_ACCESS_CYC = (PRECHARGE_ACCESS_NS + CLK_NS - 1) / CLK_NS;
   // longest time: refresh interval per row rounds down
   localparam int REFRESH_INTERVAL_CYC = (REFRESH_MS * 1000000 / CLK_NS) / REFRESH_ROWS;
   // ************************************************************
   // widths and field positions
   // ************************************************************
   localparam int ADDR_W = 9;      // multiplexed address lines
   localparam int DATA_W = 16;     // data lines
   localparam int ROW_LSB = 9;     // row field of the cell address
   localparam int COL_LSB = 0;     // column field of the cell address
   localparam int LOW_LANE_LSB = 8; // lower byte strobe lane sits on lines 8..15
   localparam int UP_LANE_LSB = 0;  // upper byte strobe lane sits on lines 0..7
   localparam logic [1:0] LANES_NONE = 2'h0;
   // ************************************************************
   // request carrier
   // ************************************************************
   typedef struct packed {
      logic write;          // one for write, zero for read
      logic [17:0] addr;    // row in high nine bits, column in low
      logic [1:0] lanes;    // bit1 lower byte strobe, bit0 upper byte strobe
      logic [15:0] wdata;   // write data
   } dspd_req_s;
   // pin bundle towards the memory
   typedef struct packed {
      logic ras_n;              // row strobe
      logic lower_byte_column_strobe_n;             // lower byte column strobe
      logic upper_byte_column_strobe_n;             // upper byte column strobe
      logic we_n;               // write select
      logic oe_n;               // output enable
      logic [8:0] addr;         // multiplexed address lines
   } dspd_pins_s;
endpackage : dspd_pkg

/* File: dspd_timer.sv */
/*
 * small down counter giving a one-cycle done pulse after a loaded count.
 * a new load restarts the count at any time, even before done has fired.
 */
`timescale 1ns/100ps
`default_nettype none
module dspd_timer #(
   parameter int W = 16
) (
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic load,
   input wire logic [W-1:0] count,
   output logic done
);
   logic [W-1:0] cnt_ff; // remaining cycles
   logic run_ff;         // counting
   // ************************************************************
   // counter
   // ************************************************************
   // count down; done fires in the cycle the count reaches zero
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         cnt_ff <= '0;
         run_ff <= 1'b0;
      end else if (load) begin
         cnt_ff <= count;
         run_ff <= 1'b1;
      end else if (run_ff && cnt_ff != '0) begin
         cnt_ff <= cnt_ff - {{(W-1){1'b0}}, 1'b1};
      end else begin
         run_ff <= 1'b0;
      end
   end
   assign done = run_ff && (cnt_ff == '0) && !load;
endmodule : dspd_timer
`default_nettype wire

/* File: dspd_sva.sv */
/* pin checks for the dual strobe page memory controller.
   assumes one clock domain and a bind onto dspd_ctrl. */
`timescale 1ns/100ps
`default_nettype none
module dspd_sva #(
   parameter int REFRESH_CYC = 156
) (
   input wire logic REF_CLK,
   input wire logic RST,
   input wire dspd_pkg::dspd_pins_s PINS,
   input wire logic [15:0] DQ_OUT,
   input wire logic [15:0] DQ_OE
);
   import dspd_pkg::*;
   // ***************
   // helper state
   // ***************
   localparam int REF_SLACK = 16; // an access in flight may delay a refresh
   logic both_hi; // both column strobes released
   logic first_fall; // first column strobe edge of an access
   logic was_hi_ff; // strobes released one cycle ago
   logic was_ras_ff; // row strobe high one cycle ago
   logic [15:0] since_ref_ff; // cycles since the last strobe-first refresh
   assign both_hi = PINS.lower_byte_column_strobe_n & PINS.upper_byte_column_strobe_n;
   assign first_fall = was_hi_ff & ~both_hi & ~PINS.ras_n;
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RST);
   // previous levels kept in flops, not through sampled functions
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         was_hi_ff <= 1'b1;
         was_ras_ff <= 1'b1;
      end else begin
         was_hi_ff <= both_hi;
         was_ras_ff <= PINS.ras_n;
      end
   end
   // refresh age; restarts when the row strobe falls behind a column strobe
   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         since_ref_ff <= 16'h0000;
      end else if (was_ras_ff && !PINS.ras_n && !both_hi) begin
         since_ref_ff <= 16'h0000;
      end else begin
         since_ref_ff <= since_ref_ff + 16'h0001;
      end
   end
   // ***************
   // assertions
   // ***************
   AST_ADDR_AT_ROW: assert property ($fell(PINS.ras_n) && both_hi |-> $stable(PINS.addr))
      else $error("address moved at row strobe fall");
   AST_ADDR_AT_COL: assert property (first_fall |-> $stable(PINS.addr))
      else $error("address moved at column strobe fall");
   AST_COL_CHANGE: assert property (!PINS.ras_n && $past(!PINS.ras_n) && $changed(PINS.addr) |-> both_hi)
      else $error("column changed with a strobe low");
   AST_HOLD_LOW: assert property ($fell(PINS.lower_byte_column_strobe_n) && !PINS.ras_n |=> !PINS.lower_byte_column_strobe_n)
      else $error("lower strobe pulse too short");
   AST_FLOAT_FIRST: assert property (|DQ_OE |-> PINS.oe_n)
      else $error("data driven with outputs enabled");
   AST_WDATA_READY: assert property (first_fall && !PINS.we_n |-> $stable(DQ_OUT) && DQ_OE != 16'h0000)
      else $error("write data not settled at strobe fall");
   AST_LANE_DRIVE: assert property (first_fall && !PINS.we_n |->
      DQ_OE == {{8{~PINS.lower_byte_column_strobe_n}}, {8{~PINS.upper_byte_column_strobe_n}}})
      else $error("driven lanes differ from strobes");
   AST_OVERLAP: assert property (!($rose(PINS.lower_byte_column_strobe_n) && $fell(PINS.upper_byte_column_strobe_n)) && !($rose(PINS.upper_byte_column_strobe_n) && $fell(PINS.lower_byte_column_strobe_n)))
      else $error("strobe released before the other fell");
   AST_REFRESH_DUE: assert property (since_ref_ff <= REFRESH_CYC + REF_SLACK)
      else $error("refresh overdue");
endmodule : dspd_sva
bind dspd_ctrl dspd_sva #(.REFRESH_CYC(REFRESH_CYC)) u_sva (
   .REF_CLK(REF_CLK),
   .RST(RST),
   .PINS(PINS),
   .DQ_OUT(DQ_OUT),
   .DQ_OE(DQ_OE)
);
`default_nettype wire

/* File: dspd_mem_model.sv */
/* behavioural 256K x 16 dual strobe memory.
   assumes pins from dspd_ctrl and data lines resolved by the bench. */
`timescale 1ns/100ps
`default_nettype none
module dspd_mem_model #(
   parameter int ACC_NS = 15 // strobe access delay; raise it for a slow part
) (
   input wire dspd_pkg::dspd_pins_s pins,
   input wire logic [15:0] dq,
   output logic [15:0] q,
   output logic [15:0] q_oe
);
   import dspd_pkg::*;
   logic [15:0] mem [0:262143]; // one word per cell
   logic [8:0] row; // open row, kept across page accesses
   logic [8:0] col; // column frozen at the first strobe
   logic early_wr; // write select fell before the strobes
   logic lo_on, up_on; // lane output enables before the access delay
   int acts; // row activations
   int refs; // strobe-first refreshes
   dspd_pins_s p; // pin levels before this change
   initial begin
      p = '1;
      acts = 0;
      refs = 0;
      early_wr = 1'b0;
   end
   // store only the lanes asked for
   task automatic put(input logic lo, input logic up);
      if (lo) mem[{row, col}][15:8] = dq[15:8];
      if (up) mem[{row, col}][7:0] = dq[7:0];
   endtask : put
   // edge decoding on every pin change; one process keeps edges ordered
   always @(pins) begin
      if (p.ras_n && !pins.ras_n) begin
         if (!pins.lower_byte_column_strobe_n || !pins.upper_byte_column_strobe_n) begin
            refs++;
         end else begin
            row = pins.addr;
            acts++;
         end
      end
      if (!pins.ras_n && p.lower_byte_column_strobe_n && p.upper_byte_column_strobe_n && !(pins.lower_byte_column_strobe_n && pins.upper_byte_column_strobe_n)) begin
         col = pins.addr;
         early_wr = !pins.we_n;
      end
      if (pins.lower_byte_column_strobe_n && pins.upper_byte_column_strobe_n) early_wr = 1'b0;
      if (!pins.ras_n && !pins.we_n) put(p.lower_byte_column_strobe_n && !pins.lower_byte_column_strobe_n, p.upper_byte_column_strobe_n && !pins.upper_byte_column_strobe_n);
      if (!pins.ras_n && p.we_n && !pins.we_n) put(!pins.lower_byte_column_strobe_n, !pins.upper_byte_column_strobe_n);
      p = pins;
   end
   // outputs follow the pins unlatched, each strobe its own lane
   assign lo_on = !pins.ras_n && !pins.oe_n && !pins.lower_byte_column_strobe_n && !early_wr;
   assign up_on = !pins.ras_n && !pins.oe_n && !pins.upper_byte_column_strobe_n && !early_wr;
   assign #(ACC_NS) q_oe = {{8{lo_on}}, {8{up_on}}};
   assign q = mem[{row, col}];
endmodule : dspd_mem_model
`default_nettype wire

/* File: test_dual_strobe_page_dram_port.sv */
/* self-checking bench for dspd_ctrl against a behavioural memory.
   assumes the checker binds itself from its own file. */
`timescale 1ns/100ps
`default_nettype none
module test_dual_strobe_page_dram_port;
   import dspd_pkg::*;
   localparam int RCYC = 40; // shortened refresh interval
   localparam logic [8:0] PCOL [3] = '{9'h000, 9'h1FF, 9'h055}; // page columns
   logic ref_clk, rst, req_valid, req_ready, rsp_valid;
   dspd_req_s req;
   dspd_pins_s pins;
   logic [15:0] rsp_data, dq_bus, dq_out, dq_oe, m_q, m_oe, rd;
   int err_total, checks_done;
   // released lines show the inverse of the last word, no pull
   assign dq_bus = (dq_oe & dq_out) | (~dq_oe & m_oe & m_q) | (~dq_oe & ~m_oe & ~m_q);
   always #50 ref_clk = ~ref_clk;
   dspd_ctrl #(.REFRESH_CYC(RCYC)) dut (.REF_CLK(ref_clk), .RST(rst), .REQ_VALID(req_valid),
      .REQ_READY(req_ready), .REQ(req), .RSP_VALID(rsp_valid), .RSP_DATA(rsp_data),
      .PINS(pins), .DQ_IN(dq_bus), .DQ_OUT(dq_out), .DQ_OE(dq_oe));
   dspd_mem_model u_mem (.pins(pins), .dq(dq_bus), .q(m_q), .q_oe(m_oe));
   task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // one request: held until taken, then wait for the response pulse
   task automatic xfer(input logic wr, input logic [17:0] a, input logic [1:0] ln,
      input logic [15:0] d);
      int n;
      @(negedge ref_clk);
      req_valid = 1'b1;
      req = '{write: wr, addr: a, lanes: ln, wdata: d};
      n = 0;
      while (req_ready !== 1'b1 && n < 50) begin
         @(negedge ref_clk);
         n++;
      end
      @(negedge ref_clk);
      req_valid = 1'b0;
      chk("busy after take", {15'h0000, req_ready}, 16'h0000);
      n = 0;
      while (rsp_valid !== 1'b1 && n < 20) begin
         @(negedge ref_clk);
         n++;
      end
      chk("response", {15'h0000, rsp_valid}, 16'h0001);
      rd = rsp_data;
   endtask : xfer
   task automatic t_rows();
      xfer(1'b1, 18'h3FE01, 2'h3, 16'hA55A);
      xfer(1'b1, 18'h00123, 2'h3, 16'h1234);
      xfer(1'b0, 18'h3FE01, 2'h3, 16'h0000);
      chk("row miss read", rd, 16'hA55A);
      chk("stored cell", u_mem.mem[18'h00123], 16'h1234);
      $display("test rows done");
   endtask : t_rows
   task automatic t_lanes();
      xfer(1'b1, 18'h00123, 2'h2, 16'hBEEF);
      chk("lower lane write", u_mem.mem[18'h00123], 16'hBE34);
      xfer(1'b0, 18'h00123, 2'h1, 16'h0000);
      chk("upper lane read", rd, 16'h0034);
      xfer(1'b0, 18'h00123, 2'h2, 16'h0000);
      chk("lower lane read", rd, 16'hBE00);
      $display("test lanes done");
   endtask : t_lanes
   // row opened first; afterwards each refresh adds exactly one activation
   task automatic t_page();
      int a0, r0, i;
      xfer(1'b1, {9'h0AA, PCOL[0]}, 2'h3, {7'h00, PCOL[0]} ^ 16'hC3C3);
      a0 = u_mem.acts;
      r0 = u_mem.refs;
      for (i = 1; i < 3; i++) xfer(1'b1, {9'h0AA, PCOL[i]}, 2'h3, {7'h00, PCOL[i]} ^ 16'hC3C3);
      for (i = 0; i < 3; i++) begin
         xfer(1'b0, {9'h0AA, PCOL[i]}, 2'h3, 16'h0000);
         chk("page read", rd, {7'h00, PCOL[i]} ^ 16'hC3C3);
      end
      chk("row opens", 16'(u_mem.acts - a0), 16'(u_mem.refs - r0));
      $display("test page done");
   endtask : t_page
   task automatic t_refresh();
      int r0;
      r0 = u_mem.refs;
      repeat (2 * RCYC + 10) @(negedge ref_clk);
      chk("refresh pace", {15'h0000, (u_mem.refs - r0) >= 2}, 16'h0001);
      xfer(1'b0, 18'h3FE01, 2'h3, 16'h0000);
      chk("data kept", rd, 16'hA55A);
      $display("test refresh done");
   endtask : t_refresh
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : wrap_up
   initial begin
      ref_clk = 1'b0;
      rst = 1'b1;
      req_valid = 1'b0;
      req = '0;
      err_total = 0;
      checks_done = 0;
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      rst = 1'b0;
      t_rows();
      t_lanes();
      t_page();
      t_refresh();
      wrap_up();
   end
   // watchdog well past the few hundred cycles the tests need
   initial begin
      #(20000 * 100);
      err_total++;
      wrap_up();
   end
endmodule : test_dual_strobe_page_dram_port
`default_nettype wire
